// ### mld_pkg.sv
package mld_pkg;
	// ********************************************************************
	// Register map and field layout.
	// ********************************************************************
	localparam int AXI_AW = 6;
	localparam logic [5:0] OFF_CMD = 6'h00;
	localparam logic [5:0] OFF_TCR = 6'h04;
	localparam logic [5:0] OFF_DCR = 6'h08;
	localparam logic [5:0] OFF_TX_PAGE_START_REG = 6'h0c;
	localparam logic [5:0] OFF_TBC_LO = 6'h10;
	localparam logic [5:0] OFF_TBC_HI = 6'h14;
	localparam logic [5:0] OFF_ISR = 6'h18;
	localparam logic [5:0] OFF_RSR = 6'h1c;
	localparam logic [5:0] OFF_FIFO = 6'h20;
	localparam logic [5:0] OFF_STA_LO = 6'h24;
	localparam logic [5:0] OFF_STA_HI = 6'h28;
	localparam logic [5:0] OFF_LINE = 6'h2c;
	localparam int CMD_TX_BIT = 2;
	localparam int TCR_CRC_INH_BIT = 0;
	localparam int DCR_WTS_BIT = 0;
	localparam int ISR_SENT_BIT = 1;
	localparam int ISR_UNDER_BIT = 3;
	localparam int RSR_INTACT_BIT = 0;
	localparam int RSR_CRC_BIT = 1;
	localparam logic [2:0] TCR_RST = 3'h0;
	localparam logic [1:0] DCR_RST = 2'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [47:0] STA_RST = 48'h0000_0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ********************************************************************
	// Loop modes, FIFO geometry and line timing.
	// ********************************************************************
	localparam logic [1:0] LOOP_NORMAL = 2'h0;
	localparam logic [1:0] LOOP_SERIAL = 2'h1;
	localparam logic [1:0] LOOP_CODEC = 2'h2;
	localparam logic [1:0] LOOP_CABLE = 2'h3;
	localparam logic [3:0] HALF_DEPTH = 4'h8;
	localparam logic [3:0] BURST_THRESHOLD = 4'h4;
	localparam logic [5:0] PREAMBLE_LAST = 6'h37;
	localparam logic [5:0] BYTE_LAST = 6'h07;
	localparam logic [5:0] CRC_LAST = 6'h1f;
	localparam logic [7:0] SYNC_BYTE = 8'hd5;
	localparam logic [15:0] ADDR_BYTES = 16'h0006;
	localparam logic [2:0] ADV_CLKS = 3'h3;
	localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
	localparam logic [31:0] CRC_RESIDUE = 32'hc704_dd7b;
	typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_SYNC = 3'h3, TX_DATA = 3'h2,
		TX_CRC = 3'h6} mld_tx_t;
	typedef enum logic [2:0] {RX_HUNT = 3'h0, RX_DATA = 3'h1, RX_CNT_LO = 3'h3, RX_CNT_HI = 3'h2,
		RX_CNT_HI2 = 3'h6} mld_rx_t;
endpackage

// ### mld_sync3.sv
`timescale 1ns/1ps
module mld_sync3 #(
	parameter int W = 5
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} mld_sync_t;
	mld_sync_t st_r;
	mld_sync_t st_nxt;
	// A change is taken only once the last two stages agree.
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.stable = (st_r.s2 & st_r.s3) | (st_r.stable & (st_r.s2 | st_r.s3));
	end
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.stable;
endmodule // mld_sync3

// ### mld_crc32.sv
`timescale 1ns/1ps
module mld_crc32 (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic init,
	input wire logic en,
	input wire logic din,
	output logic [31:0] crc
);
	import mld_pkg::*;
	typedef struct packed {
		logic [31:0] crc;
	} mld_crc_t;
	mld_crc_t st_r;
	mld_crc_t st_nxt;
	// Bit-serial, first bit of each byte is its least significant one.
	always_comb begin
		st_nxt = st_r;
		if (init) begin
			st_nxt.crc = CRC_INIT;
		end else if (en) begin
			st_nxt.crc = {st_r.crc[30:0], 1'b0} ^ ((st_r.crc[31] ^ din) ? CRC_POLY : 32'h0000_0000);
		end
	end
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st_r <= '{crc: CRC_INIT};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign crc = st_r.crc;
endmodule // mld_crc32

// ### mld_loopback.sv
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - In any loop mode the FIFO splits into transmit and receive halves.
// - Loopback fetches single bytes from buffer memory only.
// - Only the final eight received bytes remain for the host.
// - Select 01 ties serializer output straight to deserializer input.
// - Select 10 raises the codec loop control output.
// - Select 11 goes through the cable; link failure disables the transmitter.
// - Carrier sense and collision are masked while looping.
// - FIFO port read advances pointer within four clocks; early reads wait.
// - Received bytes start at location zero and wrap, overwriting older ones.
// - After the last byte: count low, count high, count high again.
// - Transmit DMA fills FIFO, decrements count, restarts below threshold.
// - Transmitter sends 56 preamble bits then an 8-bit sync pattern.
// - CRC inhibit clear appends four CRC bytes; set sends FIFO bytes only.
// - Loopback transmission end sets the packet sent flag.
// - Receiver waits for sync, strips preamble, stores and counts bytes.
// - Inhibit clear checks CRC; inhibit set flags CRC error on matches.
// - Receive status shows intact even on mismatch; CRC error needs match.
module mld_loopback (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [mld_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [mld_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic MEM_REQ,
	output logic [15:0] MEM_ADDR,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA,
	output logic TX_BIT,
	output logic TX_EN,
	output logic CODEC_LOOP,
	input wire logic RX_BIT,
	input wire logic RX_EN,
	input wire logic CRS,
	input wire logic COL,
	input wire logic LINK_OK
);
	import mld_pkg::*;
	typedef struct packed {
		logic aw_have;
		logic [5:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] transmit_config_reg;
		logic [1:0] data_config_reg;
		logic [7:0] page;
		logic [15:0] tbc;
		logic [47:0] station;
		logic [7:0] interrupt_status_reg;
		logic [7:0] receive_status_reg;
		logic [2:0] line_stat;
		logic [15:0][7:0] fifo;
		logic [2:0] tx_wr;
		logic [2:0] tx_rd;
		logic [3:0] tx_occ;
		logic [2:0] rx_wr;
		logic [2:0] rx_rd;
		logic [2:0] adv_cnt;
		logic tx_busy;
		logic burst;
		logic mem_req;
		logic [15:0] dma_addr;
		logic [15:0] dma_cnt;
		mld_tx_t tx_st;
		logic [5:0] tx_bits;
		logic [7:0] tx_sh;
		logic line_bit;
		logic line_en;
		logic pin_en;
		logic codec_loop;
		mld_rx_t rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_bits;
		logic [15:0] rx_cnt;
		logic addr_ok;
		logic [3:0] rx_pipe;
	} mld_state_t;

	function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	mld_state_t st_r;
	mld_state_t st_nxt;
	logic [3:0] pins_s;
	logic [31:0] crc_tx;
	logic [31:0] crc_rx;
	logic [1:0] loop_sel;
	logic looping;
	logic aw_ready;
	logic w_ready;
	logic ar_ready;
	logic mem_fire;
	logic push;
	logic pop;
	logic need_byte;
	logic tx_finish;
	logic [15:0] step;
	logic rx_bit;
	logic rx_en;
	logic [7:0] rx_sh_n;
	logic crc_inh;

	mld_sync3 #(.W(4)) u_sync (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.d({LINK_OK, COL, CRS, RX_EN}),
		.q(pins_s)
	);
	mld_crc32 u_crc_tx (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.init(st_r.tx_st == TX_IDLE),
		.en(st_r.tx_st == TX_DATA || st_r.tx_st == TX_CRC),
		.din(st_r.tx_st == TX_CRC ? crc_tx[31] : st_r.tx_sh[0]),
		.crc(crc_tx)
	);
	mld_crc32 u_crc_rx (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.init(st_r.rx_st == RX_HUNT),
		.en(st_r.rx_st == RX_DATA && rx_en),
		.din(rx_bit),
		.crc(crc_rx)
	);

	assign loop_sel = st_r.transmit_config_reg[2:1];
	assign looping = loop_sel != LOOP_NORMAL;
	assign crc_inh = st_r.transmit_config_reg[TCR_CRC_INH_BIT];
	assign aw_ready = !st_r.aw_have && !st_r.bvalid;
	assign w_ready = !st_r.w_have && !st_r.bvalid;
	// A FIFO read arriving before the previous advance lands is held off.
	assign ar_ready = !st_r.rvalid && !(S_AXI_ARADDR == OFF_FIFO && st_r.adv_cnt != 3'h0);
	assign mem_fire = st_r.mem_req && MEM_ACK;
	assign step = st_r.data_config_reg[DCR_WTS_BIT] ? 16'h0002 : 16'h0001;
	// Serial loop feeds the deserializer from the serializer, never from the pins.
	// The line bit may change on every clock, which the agreement filter would swallow, so it takes a
	// plain four-stage pipeline instead; that matches the filter's delay on the frame enable.
	assign rx_bit = (loop_sel == LOOP_SERIAL) ? st_r.line_bit : st_r.rx_pipe[3];
	assign rx_en = (loop_sel == LOOP_SERIAL) ? st_r.line_en : (looping && pins_s[0]);
	assign rx_sh_n = {rx_bit, st_r.rx_sh[7:1]};

	// ********************************************************************
	// Next-state logic.
	// ********************************************************************
	always_comb begin
		st_nxt = st_r;
		push = 1'b0;
		pop = 1'b0;
		need_byte = 1'b0;
		tx_finish = 1'b0;
		// Register bus.
		if (S_AXI_AWVALID && aw_ready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && w_ready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.w_data = S_AXI_WDATA;
			st_nxt.w_strb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_have && st_r.w_have) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.aw_addr)
				OFF_CMD: begin
					if (st_r.w_strb[0] && st_r.w_data[CMD_TX_BIT] && looping && !st_r.tx_busy) begin
						st_nxt.tx_busy = 1'b1;
						st_nxt.dma_addr = {st_r.page, 8'h00};
						st_nxt.dma_cnt = st_r.tbc;
						st_nxt.tx_wr = 3'h0;
						st_nxt.tx_rd = 3'h0;
						st_nxt.tx_occ = 4'h0;
					end
				end
				OFF_TCR: st_nxt.transmit_config_reg = 3'(wr_merge({29'h0, st_r.transmit_config_reg}, st_r.w_data, st_r.w_strb));
				OFF_DCR: st_nxt.data_config_reg = 2'(wr_merge({30'h0, st_r.data_config_reg}, st_r.w_data, st_r.w_strb));
				OFF_TX_PAGE_START_REG: st_nxt.page = 8'(wr_merge({24'h0, st_r.page}, st_r.w_data, st_r.w_strb));
				OFF_TBC_LO: st_nxt.tbc[7:0] = 8'(wr_merge({24'h0, st_r.tbc[7:0]}, st_r.w_data, st_r.w_strb));
				OFF_TBC_HI: st_nxt.tbc[15:8] = 8'(wr_merge({24'h0, st_r.tbc[15:8]}, st_r.w_data, st_r.w_strb));
				OFF_ISR: begin
					if (st_r.w_strb[0]) begin
						st_nxt.interrupt_status_reg = st_r.interrupt_status_reg & ~st_r.w_data[7:0];
					end
				end
				OFF_STA_LO: st_nxt.station[31:0] = wr_merge(st_r.station[31:0], st_r.w_data, st_r.w_strb);
				OFF_STA_HI: st_nxt.station[47:32] = 16'(wr_merge({16'h0, st_r.station[47:32]}, st_r.w_data,
					st_r.w_strb));
				OFF_RSR, OFF_FIFO, OFF_LINE: st_nxt.bresp = RESP_OKAY;
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			st_nxt.rvalid = 1'b0;
		end
		if (st_r.adv_cnt != 3'h0) begin
			st_nxt.adv_cnt = st_r.adv_cnt - 3'h1;
			if (st_r.adv_cnt == 3'h1) begin
				st_nxt.rx_rd = st_r.rx_rd + 3'h1;
			end
		end
		if (S_AXI_ARVALID && ar_ready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			case (S_AXI_ARADDR)
				OFF_CMD: st_nxt.rdata = {29'h0, st_r.tx_busy, 2'h0};
				OFF_TCR: st_nxt.rdata = {29'h0, st_r.transmit_config_reg};
				OFF_DCR: st_nxt.rdata = {30'h0, st_r.data_config_reg};
				OFF_TX_PAGE_START_REG: st_nxt.rdata = {24'h0, st_r.page};
				OFF_TBC_LO: st_nxt.rdata = {24'h0, st_r.tbc[7:0]};
				OFF_TBC_HI: st_nxt.rdata = {24'h0, st_r.tbc[15:8]};
				OFF_ISR: st_nxt.rdata = {24'h0, st_r.interrupt_status_reg};
				OFF_RSR: st_nxt.rdata = {24'h0, st_r.receive_status_reg};
				OFF_FIFO: begin
					// Outside loopback the port reads zero and the pointer stays put.
					st_nxt.rdata = looping ? {24'h0, st_r.fifo[{1'b1, st_r.rx_rd}]} : 32'h0;
					st_nxt.adv_cnt = looping ? ADV_CLKS : 3'h0;
				end
				OFF_STA_LO: st_nxt.rdata = st_r.station[31:0];
				OFF_STA_HI: st_nxt.rdata = {16'h0, st_r.station[47:32]};
				OFF_LINE: st_nxt.rdata = {29'h0, st_r.line_stat};
				default: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		// Transmit DMA: bursts restart only once the transmit half drains below threshold.
		if (st_r.tx_busy && !st_r.burst && st_r.dma_cnt != 16'h0 && st_r.tx_occ < BURST_THRESHOLD) begin
			st_nxt.burst = 1'b1;
		end
		if (st_r.burst && !st_r.mem_req && st_r.tx_occ < HALF_DEPTH && st_r.dma_cnt != 16'h0) begin
			st_nxt.mem_req = 1'b1;
		end
		if (mem_fire) begin
			st_nxt.mem_req = 1'b0;
			push = 1'b1;
			st_nxt.fifo[{1'b0, st_r.tx_wr}] = MEM_RDATA;
			st_nxt.tx_wr = st_r.tx_wr + 3'h1;
			st_nxt.dma_addr = st_r.dma_addr + step;
			st_nxt.dma_cnt = (st_r.dma_cnt > step) ? st_r.dma_cnt - step : 16'h0;
			if (st_r.tx_occ == HALF_DEPTH - 4'h1 || st_r.dma_cnt <= step) begin
				st_nxt.burst = 1'b0;
			end
		end
		// Serializer.
		case (st_r.tx_st)
			TX_IDLE: begin
				st_nxt.tx_bits = 6'h0;
				if (st_r.tx_busy && st_r.tx_occ != 4'h0) begin
					st_nxt.tx_st = TX_PRE;
				end
			end
			TX_PRE: begin
				st_nxt.line_bit = ~st_r.tx_bits[0];
				st_nxt.tx_bits = st_r.tx_bits + 6'h1;
				if (st_r.tx_bits == PREAMBLE_LAST) begin
					st_nxt.tx_st = TX_SYNC;
					st_nxt.tx_bits = 6'h0;
				end
			end
			TX_SYNC: begin
				st_nxt.line_bit = SYNC_BYTE[st_r.tx_bits[2:0]];
				st_nxt.tx_bits = st_r.tx_bits + 6'h1;
				need_byte = st_r.tx_bits == BYTE_LAST;
			end
			TX_DATA: begin
				st_nxt.line_bit = st_r.tx_sh[0];
				st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
				st_nxt.tx_bits = st_r.tx_bits + 6'h1;
				need_byte = st_r.tx_bits == BYTE_LAST;
			end
			TX_CRC: begin
				st_nxt.line_bit = ~crc_tx[31];
				st_nxt.tx_bits = st_r.tx_bits + 6'h1;
				tx_finish = st_r.tx_bits == CRC_LAST;
			end
			default: st_nxt.tx_st = TX_IDLE;
		endcase
		if (need_byte) begin
			st_nxt.tx_bits = 6'h0;
			if (st_r.tx_occ != 4'h0) begin
				pop = 1'b1;
				st_nxt.tx_sh = st_r.fifo[{1'b0, st_r.tx_rd}];
				st_nxt.tx_rd = st_r.tx_rd + 3'h1;
				st_nxt.tx_st = TX_DATA;
			end else if (st_r.dma_cnt == 16'h0) begin
				if (crc_inh) begin
					tx_finish = 1'b1;
				end else begin
					st_nxt.tx_st = TX_CRC;
				end
			end else begin
				// Memory too slow to keep up; the frame is cut short.
				tx_finish = 1'b1;
				st_nxt.interrupt_status_reg[ISR_UNDER_BIT] = 1'b1;
			end
		end
		if (tx_finish) begin
			st_nxt.tx_st = TX_IDLE;
			st_nxt.tx_busy = 1'b0;
			st_nxt.burst = 1'b0;
			st_nxt.interrupt_status_reg[ISR_SENT_BIT] = 1'b1;
		end
		st_nxt.tx_occ = st_r.tx_occ + {3'h0, push} - {3'h0, pop};
		st_nxt.line_en = st_r.tx_st != TX_IDLE;
		st_nxt.pin_en = st_r.tx_st != TX_IDLE && loop_sel != LOOP_SERIAL
			&& !(loop_sel == LOOP_CABLE && !pins_s[3]);
		st_nxt.codec_loop = loop_sel == LOOP_CODEC;
		st_nxt.line_stat = {pins_s[3], pins_s[2] && !looping, pins_s[1] && !looping};
		st_nxt.rx_pipe = {st_r.rx_pipe[2:0], RX_BIT};
		// Deserializer.
		case (st_r.rx_st)
			RX_HUNT: begin
				if (rx_en) begin
					st_nxt.rx_sh = rx_sh_n;
					if (rx_sh_n == SYNC_BYTE) begin
						st_nxt.rx_st = RX_DATA;
						st_nxt.rx_bits = 3'h0;
						st_nxt.rx_cnt = 16'h0;
						st_nxt.rx_wr = 3'h0;
						st_nxt.rx_rd = 3'h0;
						st_nxt.addr_ok = 1'b1;
					end
				end
			end
			RX_DATA: begin
				if (!rx_en) begin
					st_nxt.rx_st = RX_CNT_LO;
				end else begin
					st_nxt.rx_sh = rx_sh_n;
					st_nxt.rx_bits = st_r.rx_bits + 3'h1;
					if (st_r.rx_bits == 3'h7) begin
						st_nxt.fifo[{1'b1, st_r.rx_wr}] = rx_sh_n;
						st_nxt.rx_wr = st_r.rx_wr + 3'h1;
						st_nxt.rx_cnt = st_r.rx_cnt + 16'h1;
						if (st_r.rx_cnt < ADDR_BYTES && rx_sh_n != st_r.station[st_r.rx_cnt[2:0]*8 +: 8]) begin
							st_nxt.addr_ok = 1'b0;
						end
					end
				end
			end
			RX_CNT_LO: begin
				st_nxt.fifo[{1'b1, st_r.rx_wr}] = st_r.rx_cnt[7:0];
				st_nxt.rx_wr = st_r.rx_wr + 3'h1;
				st_nxt.rx_st = RX_CNT_HI;
			end
			RX_CNT_HI: begin
				st_nxt.fifo[{1'b1, st_r.rx_wr}] = st_r.rx_cnt[15:8];
				st_nxt.rx_wr = st_r.rx_wr + 3'h1;
				st_nxt.rx_st = RX_CNT_HI2;
			end
			RX_CNT_HI2: begin
				st_nxt.fifo[{1'b1, st_r.rx_wr}] = st_r.rx_cnt[15:8];
				st_nxt.rx_wr = st_r.rx_wr + 3'h1;
				st_nxt.rx_st = RX_HUNT;
				st_nxt.receive_status_reg = 8'h00;
				st_nxt.receive_status_reg[RSR_CRC_BIT] = st_r.addr_ok && (crc_inh || crc_rx != CRC_RESIDUE);
				st_nxt.receive_status_reg[RSR_INTACT_BIT] = !(st_r.addr_ok && (crc_inh || crc_rx != CRC_RESIDUE));
			end
			default: st_nxt.rx_st = RX_HUNT;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			st_r <= '0;
			st_r.transmit_config_reg <= TCR_RST;
			st_r.data_config_reg <= DCR_RST;
			st_r.page <= BYTE_RST;
			st_r.interrupt_status_reg <= BYTE_RST;
			st_r.receive_status_reg <= BYTE_RST;
			st_r.station <= STA_RST;
			st_r.tx_st <= TX_IDLE;
			st_r.rx_st <= RX_HUNT;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign S_AXI_AWREADY = aw_ready;
	assign S_AXI_WREADY = w_ready;
	assign S_AXI_BVALID = st_r.bvalid;
	assign S_AXI_BRESP = st_r.bresp;
	assign S_AXI_ARREADY = ar_ready;
	assign S_AXI_RVALID = st_r.rvalid;
	assign S_AXI_RDATA = st_r.rdata;
	assign S_AXI_RRESP = st_r.rresp;
	assign MEM_REQ = st_r.mem_req;
	assign MEM_ADDR = st_r.dma_addr;
	assign TX_BIT = st_r.line_bit;
	assign TX_EN = st_r.pin_en;
	assign CODEC_LOOP = st_r.codec_loop;

	// ********************************************************************
	// Checks.
	// ********************************************************************
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SRST);
	AST_TX_HALF: assert property (st_r.tx_occ <= HALF_DEPTH && (!push || st_r.tx_occ < HALF_DEPTH))
		else $error("transmit half overfilled");
	AST_DMA_STEP: assert property ((mem_fire && !st_r.data_config_reg[DCR_WTS_BIT]) |=>
		(st_r.dma_cnt == $past(st_r.dma_cnt) - 16'h1 && st_r.dma_addr == $past(st_r.dma_addr) + 16'h1))
		else $error("byte fetch did not step count and address by one");
	AST_RX_START: assert property ((st_r.rx_st == RX_HUNT && rx_en && rx_sh_n == SYNC_BYTE) |=>
		(st_r.rx_st == RX_DATA && st_r.rx_wr == 3'h0 && st_r.rx_cnt == 16'h0))
		else $error("reception did not start at location zero");
	AST_SERIAL_PINS: assert property ($past(loop_sel) == LOOP_SERIAL |-> !TX_EN)
		else $error("serial loop drove the line");
	AST_CODEC_LOOP: assert property (loop_sel == LOOP_CODEC && $stable(loop_sel) |=> CODEC_LOOP)
		else $error("codec loop control missing");
	AST_LINK_FAIL: assert property ((loop_sel == LOOP_CABLE && !pins_s[3]) |=> !TX_EN)
		else $error("transmitter active on failed link");
	AST_MASK: assert property (looping |=> st_r.line_stat[1:0] == 2'h0)
		else $error("carrier or collision not masked");
	AST_ADV: assert property ((S_AXI_ARVALID && ar_ready && S_AXI_ARADDR == OFF_FIFO && looping) |=>
		##3 st_r.rx_rd == $past(st_r.rx_rd, 4) + 3'h1)
		else $error("FIFO pointer did not advance in time");
	AST_PREAMBLE: assert property ((st_r.tx_st == TX_PRE && $past(st_r.tx_st) == TX_IDLE) |->
		##56 st_r.tx_st == TX_SYNC)
		else $error("preamble length wrong");
	AST_COUNT_TAIL: assert property (st_r.rx_st == RX_CNT_LO |=> st_r.rx_st == RX_CNT_HI
		##1 st_r.rx_st == RX_CNT_HI2 ##1 st_r.fifo[{1'b1, $past(st_r.rx_wr)}] == $past(st_r.rx_cnt[15:8]))
		else $error("byte count tail malformed");
	AST_SENT: assert property ((st_r.tx_st != TX_IDLE && st_nxt.tx_st == TX_IDLE) |=>
		st_r.interrupt_status_reg[ISR_SENT_BIT])
		else $error("sent flag not set");
	AST_CRC_FORCED: assert property ((st_r.rx_st == RX_CNT_HI2 && crc_inh && st_r.addr_ok) |=>
		st_r.receive_status_reg[RSR_CRC_BIT] && !st_r.receive_status_reg[RSR_INTACT_BIT])
		else $error("forced CRC error missing");
	COV_SENT: cover property (st_r.tx_st == TX_CRC ##1 st_r.tx_st == TX_IDLE);
	COV_RECEIVED: cover property (st_r.rx_st == RX_CNT_HI2);
	COV_WAIT: cover property (S_AXI_ARVALID && S_AXI_ARADDR == OFF_FIFO && !ar_ready);
endmodule // mld_loopback

// ### mld_far_model.sv
`timescale 1ns/1ps
// ****************************************
// Buffer memory and line codec stand-in.
// ****************************************
module mld_far_model #(
	parameter int LAT = 2
) (
	input wire logic clock,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	input wire logic tx_bit,
	input wire logic tx_en,
	output logic rx_bit,
	output logic rx_en
);
	int cnt = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
		rx_bit = 1'b0;
		rx_en = 1'b0;
	end
	// Data and line toggle when not valid, so a stale value can never pass.
	always @(posedge clock) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		rx_en <= tx_en;
		rx_bit <= tx_en ? tx_bit : ~rx_bit;
		if (mem_req && !mem_ack) begin
			cnt <= (cnt == LAT) ? 0 : cnt + 1;
			if (cnt == LAT) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_addr[7:0];
			end
		end
	end
endmodule // mld_far_model

// ### mld_loopback_tb.sv
`timescale 1ns/1ps
module mld_loopback_tb;
	import mld_pkg::*;
	// ****************************************
	// Bench signals, line monitor and bus tasks.
	// ****************************************
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, arv = 1'b0, crs = 1'b0, col = 1'b0, link = 1'b1;
	logic [5:0] aw = 6'h00, ar = 6'h00;
	logic [31:0] wd = 32'h0, rd, rdat;
	logic [1:0] rr, br, rresp;
	logic awr, wr, bv, arr, rv, mreq, mack, txb, txe, cloop, rxb, rxe;
	logic [15:0] maddr;
	logic [7:0] mdat;
	logic [63:0] pre = 64'h0;
	int nb = 0, frames = 0, last = 0, fails = 0, num_checks = 0;
	mld_loopback DUT (.CLOCK(clock), .SRST(srst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(aw), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(1'b1), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .MEM_REQ(mreq),
		.MEM_ADDR(maddr), .MEM_ACK(mack), .MEM_RDATA(mdat), .TX_BIT(txb), .TX_EN(txe),
		.CODEC_LOOP(cloop), .RX_BIT(rxb), .RX_EN(rxe), .CRS(crs), .COL(col), .LINK_OK(link));
	mld_far_model #(.LAT(2)) far (.clock(clock), .mem_req(mreq), .mem_addr(maddr), .mem_ack(mack),
		.mem_rdata(mdat), .tx_bit(txb), .tx_en(txe), .rx_bit(rxb), .rx_en(rxe));
	initial forever #2 clock = ~clock;
	always @(negedge clock) begin
		if (txe) begin
			if (nb < 64) pre <= {txb, pre[63:1]};
			nb <= nb + 1;
		end else if (nb != 0) begin
			last <= nb;
			frames <= frames + 1;
			nb <= 0;
		end
	end
	task automatic test_done();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr32(input logic [5:0] a, input logic [31:0] d);
		bit da, dw, ta, tw;
		int n;
		da = 0;
		dw = 0;
		n = 0;
		@(posedge clock);
		awv <= 1'b1;
		wv <= 1'b1;
		aw <= a;
		wd <= d;
		while (!(da && dw) && n < 100) begin
			@(negedge clock);
			ta = awr;
			tw = wr;
			@(posedge clock);
			if (ta) begin
				awv <= 1'b0;
				da = 1;
			end
			if (tw) begin
				wv <= 1'b0;
				dw = 1;
			end
			n++;
		end
		do @(negedge clock); while (!bv && ++n < 200);
		chk(bv, 1'b1);
		@(posedge clock);
	endtask
	task automatic rd32(input logic [5:0] a);
		int n;
		n = 0;
		@(posedge clock);
		arv <= 1'b1;
		ar <= a;
		do @(negedge clock); while (!arr && ++n < 100);
		@(posedge clock);
		arv <= 1'b0;
		do @(negedge clock); while (!rv && ++n < 200);
		rd = rdat;
		rr = rresp;
		chk(rv, 1'b1);
	endtask
	// Always passes through normal mode first, the far side may not switch directly.
	task automatic send(input logic [31:0] transmit_config_reg, input bit interrupt_status_reg);
		int n;
		wr32(OFF_TCR, 32'h0);
		wr32(OFF_TCR, transmit_config_reg);
		wr32(OFF_CMD, 32'h4);
		n = 0;
		do rd32(OFF_CMD); while (rd[CMD_TX_BIT] !== 1'b0 && ++n < 500);
		chk(rd[CMD_TX_BIT], 1'b0);
		repeat (30) @(posedge clock);
		rd32(OFF_ISR);
		if (interrupt_status_reg) chk(rd[ISR_SENT_BIT], 1'b1);
		wr32(OFF_ISR, 32'h2);
	endtask
	task automatic fifo(input logic [63:0] e, input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			rd32(OFF_FIFO);
			if (m[i]) chk(rd, {56'h0, e[8*i +: 8]});
		end
	endtask
	// ****************************************
	// Scenarios.
	// ****************************************
	initial begin
		#200000;
		fails++;
		test_done();
	end
	task automatic scn_regs();
		rd32(OFF_TCR);
		chk(rd, 32'h0);
		rd32(6'h30);
		chk({rr, rd}, {RESP_SLVERR, 32'h0});
		wr32(6'h30, 32'h0);
		chk(br, RESP_SLVERR);
		wr32(OFF_STA_LO, 32'h03020100);
		wr32(OFF_STA_HI, 32'h0504);
		wr32(OFF_TX_PAGE_START_REG, 32'h1);
		wr32(OFF_TBC_LO, 32'h8);
		wr32(OFF_TBC_HI, 32'h0);
	endtask
	task automatic scn_codec();
		crs <= 1'b1;
		col <= 1'b1;
		send(32'h5, 1);
		chk(cloop, 1'b1);
		chk(pre, 64'hd555_5555_5555_5555);
		chk(last, 128);
		rd32(OFF_LINE);
		chk(rd, 32'h4);
		rd32(OFF_RSR);
		chk(rd, 32'h2);
		fifo(64'h0706_0504_0300_0008, 8'hff);
	endtask
	task automatic scn_serial();
		wr32(OFF_TBC_LO, 32'h6);
		send(32'h2, 1);
		chk(frames, 1);
		rd32(OFF_RSR);
		chk(rd, 32'h1);
		fifo(64'h0000_0500_000a_0000, 8'h3c);
	endtask
	// Word mode fetches every second byte, so the station address no longer matches.
	task automatic scn_word();
		wr32(OFF_DCR, 32'h3);
		wr32(OFF_TBC_LO, 32'h10);
		send(32'h3, 1);
		rd32(OFF_RSR);
		chk(rd, 32'h1);
		fifo(64'h0e0c_0a08_0600_0008, 8'hff);
	endtask
	task automatic scn_cable();
		link <= 1'b0;
		send(32'h6, 0);
		chk(frames, 1);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		scn_regs();
		scn_codec();
		scn_serial();
		scn_word();
		scn_cable();
		test_done();
	end
endmodule // mld_loopback_tb
